// File: hdl/baseline_tracker.sv
`timescale 1ns/10ps
`default_nettype none
module baseline_tracker
   import standby_touch_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               valid_i,
   input  wire logic               touched_i,
   input  wire logic [COUNT_W-1:0] value_i,
   input  wire logic [3:0]         scale_i,
   output logic      [COUNT_W-1:0] base_o,
   output logic      [7:0]         view_o
);

   logic [RECAL_ACC_W-1:0] acc_q;
   logic [RECAL_ACC_W-1:0] acc_d;
   logic [RECAL_LOG2-1:0]  num_q;
   logic [RECAL_LOG2-1:0]  num_d;
   logic [COUNT_W-1:0]     base_q;
   logic [COUNT_W-1:0]     base_d;
   logic [7:0]             view_q;
   logic [7:0]             view_d;
   logic [RECAL_ACC_W-1:0] acc_next;

   // Untouched readings only; a touch would drag the baseline toward itself
   always_comb
   begin
      acc_next = acc_q + RECAL_ACC_W'(value_i);
      acc_d    = acc_q;
      num_d    = num_q;
      base_d   = base_q;
      if (valid_i && !touched_i)
      begin
         num_d = num_q + 1'b1;
         if (num_q == {RECAL_LOG2{1'b1}})
         begin
            base_d = acc_next[RECAL_ACC_W-1 -: COUNT_W];
            acc_d  = '0;
         end
         else
         begin
            acc_d = acc_next;
         end
      end
      view_d = 8'(base_q >> scale_i);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         acc_q  <= '0;
         num_q  <= '0;
         base_q <= RST_BASE_INTERNAL;
         view_q <= RST_BASELINE;
      end
      else
      begin
         acc_q  <= acc_d;
         num_q  <= num_d;
         base_q <= base_d;
         view_q <= view_d;
      end
   end

   assign base_o = base_q;
   assign view_o = view_q;

endmodule
`default_nettype wire

// File: hdl/sample_accumulator.sv
`timescale 1ns/10ps
`default_nettype none
module sample_accumulator
   import standby_touch_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               clear_i,
   input  wire logic               add_i,
   input  wire logic [COUNT_W-1:0] value_i,
   output logic      [SUM_W-1:0]   sum_o
);

   logic [SUM_W-1:0] sum_q;
   logic [SUM_W-1:0] sum_d;

   // Clear starts a channel; each finished sample adds its count
   always_comb
   begin
      sum_d = sum_q;
      if (clear_i)
      begin
         sum_d = '0;
      end
      else if (add_i)
      begin
         sum_d = sum_q + SUM_W'(value_i);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sum_q <= '0;
      end
      else
      begin
         sum_q <= sum_d;
      end
   end

   assign sum_o = sum_q;

endmodule
`default_nettype wire

// File: hdl/standby_touch_pkg.sv
package standby_touch_pkg;

   // Register port widths and channel count
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 8;
   localparam int NUM_CH  = 3;

   // Register offsets
   localparam logic [7:0] OFS_SENSING_CONFIG = 8'h41;
   localparam logic [7:0] OFS_GAIN_SELECT    = 8'h42;
   localparam logic [7:0] OFS_TOUCH_THRESH   = 8'h43;
   localparam logic [7:0] OFS_CH1_BASELINE   = 8'h50;
   localparam logic [7:0] OFS_CH2_BASELINE   = 8'h51;
   localparam logic [7:0] OFS_CH3_BASELINE   = 8'h52;

   // Reset values
   localparam logic [7:0] RST_SENSING_CONFIG = 8'h39;
   localparam logic [7:0] RST_GAIN_SELECT    = 8'h02;
   localparam logic [7:0] RST_TOUCH_THRESH   = 8'h40;
   localparam logic [7:0] RST_BASELINE       = 8'hC8;
   localparam logic [7:0] READ_ZERO          = 8'h00;

   // Field layout of the sensing configuration, gain select and touch threshold registers
   localparam int SUM_SEL_BIT   = 7;
   localparam int COUNT_MSB     = 6;
   localparam int COUNT_LSB     = 4;
   localparam int SPER_MSB      = 3;
   localparam int SPER_LSB      = 2;
   localparam int CPER_MSB      = 1;
   localparam int CPER_LSB      = 0;
   localparam int GAIN_MSB      = 2;
   localparam int THRESH_MSB    = 6;
   localparam logic [7:0] GAIN_MASK   = 8'h07;
   localparam logic [7:0] THRESH_MASK = 8'h7F;

   // Measurement datapath widths
   localparam int COUNT_W = 16;
   localparam int SUM_W   = 23;           // 16-bit count summed up to 128 times
   localparam logic [7:0] DELTA_MAX = 8'hFF;

   // Recalibration: 2**RECAL_LOG2 readings per baseline update
   localparam int RECAL_LOG2  = 6;
   localparam int RECAL_ACC_W = COUNT_W + RECAL_LOG2;
   localparam logic [15:0] RST_BASE_INTERNAL = 16'h00C8;

   // Timing
   localparam int CLK_PERIOD_NS      = 40;
   localparam int SAMPLE_TIME_MIN_NS = 320000;
   localparam int CYCLE_TIME_MIN_NS  = 35000000;
   localparam int SAMPLE_BASE_CYCLES = SAMPLE_TIME_MIN_NS / CLK_PERIOD_NS;
   localparam int CYCLE_BASE_CYCLES  = CYCLE_TIME_MIN_NS / CLK_PERIOD_NS;
   localparam int STIMER_W = 24;
   localparam int CTIMER_W = 32;

   // Channel index meaning no further enabled channel
   localparam logic [1:0] CH_NONE = 2'h3;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_REDUCE = 2'b11,
      ST_SLEEP  = 2'b10
   } seq_state_t;

endpackage

// File: hdl/standby_touch_sensing.sv
`timescale 1ns/10ps
`default_nettype none
module standby_touch_sensing
   import standby_touch_pkg::*;
#(
   parameter int SAMPLE_CYCLES = SAMPLE_BASE_CYCLES,
   parameter int CYCLE_CYCLES  = CYCLE_BASE_CYCLES
)
(
   input  wire logic               CORE_CLK_I,
   input  wire logic               SRST_I,
   input  wire logic [ADDR_W-1:0]  REG_ADDR_I,
   input  wire logic [DATA_W-1:0]  REG_WDATA_I,
   input  wire logic               REG_WR_I,
   input  wire logic               REG_RD_I,
   output logic      [DATA_W-1:0]  REG_RDATA_O,
   input  wire logic               STANDBY_I,
   input  wire logic               CHANNEL1_STANDBY_ENABLE_I,
   input  wire logic               CHANNEL2_STANDBY_ENABLE_I,
   input  wire logic               CHANNEL3_STANDBY_ENABLE_I,
   input  wire logic [3:0]         BASELINE_SCALE_I,
   input  wire logic [COUNT_W-1:0] SAMPLE_COUNT_I,
   output logic                    SAMPLE_EN_O,
   output logic      [1:0]         SAMPLE_CH_O,
   output logic                    LOW_POWER_O,
   output logic      [NUM_CH-1:0]  TOUCH_O
);

   // Register file state
   logic [7:0] cfg_q, cfg_d;
   logic [7:0] gain_q, gain_d;
   logic [7:0] thr_q, thr_d;
   logic [7:0] rdata_q, rdata_d;

   // Sequencer state
   seq_state_t         st_q, st_d;
   logic [1:0]         ch_q, ch_d;
   logic [7:0]         nsamp_q, nsamp_d;
   logic [STIMER_W-1:0] stimer_q, stimer_d;
   logic [CTIMER_W-1:0] ctimer_q, ctimer_d;
   logic               en_q, en_d;
   logic               lp_q, lp_d;
   logic [NUM_CH-1:0]  touch_q, touch_d;

   // Datapath
   logic                acc_clr;
   logic                acc_add;
   logic [SUM_W-1:0]    acc_sum;
   logic [NUM_CH-1:0]   ch_en;
   logic [NUM_CH-1:0]   trk_valid;
   logic [COUNT_W-1:0]  trk_base [NUM_CH];
   logic [7:0]          trk_view [NUM_CH];
   logic                sum_sel;
   logic [2:0]          cnt_code;
   logic [1:0]          sper_code;
   logic [1:0]          cper_code;
   logic [2:0]          gain_code;
   logic [7:0]          samp_target;
   logic [STIMER_W-1:0] samp_len;
   logic [CTIMER_W-1:0] cycle_len;
   logic [SUM_W-1:0]    avg_val;
   logic [SUM_W-1:0]    result;
   logic [SUM_W-1:0]    diff;
   logic [SUM_W-1:0]    scaled;
   logic [7:0]          delta;
   logic                touch_now;
   logic [1:0]          next_ch;

   // Lowest enabled channel at or above a start index
   function automatic logic [1:0] first_enabled(input logic [1:0] from,
                                                input logic [NUM_CH-1:0] en);
      logic [1:0] pick;
      pick = CH_NONE;
      for (int i = NUM_CH - 1; i >= 0; i--)
      begin
         if (en[i] && (2'(i) >= from))
         begin
            pick = 2'(i);
         end
      end
      return pick;
   endfunction

   assign ch_en = {CHANNEL3_STANDBY_ENABLE_I, CHANNEL2_STANDBY_ENABLE_I,
                   CHANNEL1_STANDBY_ENABLE_I};

   // Field decode of the standby settings
   assign sum_sel   = cfg_q[SUM_SEL_BIT];
   assign cnt_code  = cfg_q[COUNT_MSB:COUNT_LSB];
   assign sper_code = cfg_q[SPER_MSB:SPER_LSB];
   assign cper_code = cfg_q[CPER_MSB:CPER_LSB];
   assign gain_code = gain_q[GAIN_MSB:0];

   assign samp_target = 8'h01 << cnt_code;
   assign samp_len    = STIMER_W'(SAMPLE_CYCLES) << sper_code;
   // cycle length in 35 ms steps
   assign cycle_len   = CTIMER_W'(CYCLE_CYCLES) * (CTIMER_W'(cper_code) + 32'h0000_0001);

   // Reduction of the summed samples into a delta against the baseline
   always_comb
   begin
      avg_val = acc_sum >> cnt_code;
      result  = sum_sel ? acc_sum : avg_val;
      diff    = (result > SUM_W'(trk_base[ch_q])) ? result - SUM_W'(trk_base[ch_q]) : '0;
      scaled  = diff >> gain_code;
      // Sum mode wraps on purpose; average mode saturates
      if (!sum_sel && (|scaled[SUM_W-1:8]))
      begin
         delta = DELTA_MAX;
      end
      else
      begin
         delta = scaled[7:0];
      end
      touch_now = delta > {1'b0, thr_q[THRESH_MSB:0]};
      next_ch   = first_enabled(ch_q + 2'h1, ch_en);
   end

   // Register writes and read data
   always_comb
   begin
      cfg_d   = cfg_q;
      gain_d  = gain_q;
      thr_d   = thr_q;
      rdata_d = rdata_q;
      if (REG_WR_I)
      begin
         unique case (REG_ADDR_I)
            OFS_SENSING_CONFIG: cfg_d  = REG_WDATA_I;
            OFS_GAIN_SELECT:    gain_d = REG_WDATA_I & GAIN_MASK;   // three gain bits
            OFS_TOUCH_THRESH:   thr_d  = REG_WDATA_I & THRESH_MASK;
            default:            cfg_d  = cfg_q;
         endcase
      end
      if (REG_RD_I)
      begin
         unique case (REG_ADDR_I)
            OFS_SENSING_CONFIG: rdata_d = cfg_q;
            OFS_GAIN_SELECT:    rdata_d = gain_q;
            OFS_TOUCH_THRESH:   rdata_d = thr_q;
            OFS_CH1_BASELINE:   rdata_d = trk_view[0];
            OFS_CH2_BASELINE:   rdata_d = trk_view[1];
            OFS_CH3_BASELINE:   rdata_d = trk_view[2];
            default:            rdata_d = READ_ZERO;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (SRST_I)
      begin
         cfg_q   <= RST_SENSING_CONFIG;
         gain_q  <= RST_GAIN_SELECT;
         thr_q   <= RST_TOUCH_THRESH;
         rdata_q <= READ_ZERO;
      end
      else
      begin
         cfg_q   <= cfg_d;
         gain_q  <= gain_d;
         thr_q   <= thr_d;
         rdata_q <= rdata_d;
      end
   end

   // Sensing sequencer: cycle start, per-channel sampling, reduce, sleep
   always_comb
   begin
      st_d      = st_q;
      ch_d      = ch_q;
      nsamp_d   = nsamp_q;
      stimer_d  = stimer_q;
      ctimer_d  = (ctimer_q == '1) ? ctimer_q : ctimer_q + 1'b1;
      en_d      = en_q;
      lp_d      = lp_q;
      touch_d   = touch_q;
      acc_clr   = 1'b0;
      acc_add   = 1'b0;
      trk_valid = '0;
      unique case (st_q)
         ST_IDLE:
         begin
            en_d = 1'b0;
            lp_d = 1'b0;
            if (STANDBY_I)
            begin
               // new cycle samples first; this idle cycle is the period's first
               ctimer_d = CTIMER_W'(1);
               ch_d     = first_enabled(2'h0, ch_en);
               if (first_enabled(2'h0, ch_en) != CH_NONE)
               begin
                  st_d     = ST_SAMPLE;
                  en_d     = 1'b1;
                  stimer_d = '0;
                  nsamp_d  = '0;
                  acc_clr  = 1'b1;
               end
               else
               begin
                  st_d = ST_SLEEP;
                  lp_d = 1'b1;
               end
            end
         end
         ST_SAMPLE:
         begin
            stimer_d = stimer_q + 1'b1;
            if (stimer_q == samp_len - 1'b1)
            begin
               acc_add  = 1'b1;
               stimer_d = '0;
               nsamp_d  = nsamp_q + 1'b1;
               if (nsamp_q + 8'h01 == samp_target)
               begin
                  st_d = ST_REDUCE;
                  en_d = 1'b0;
               end
            end
         end
         ST_REDUCE:
         begin
            touch_d[ch_q]   = touch_now;
            trk_valid[ch_q] = 1'b1;
            if (next_ch != CH_NONE)
            begin
               ch_d     = next_ch;
               st_d     = ST_SAMPLE;
               en_d     = 1'b1;
               stimer_d = '0;
               nsamp_d  = '0;
               acc_clr  = 1'b1;
            end
            else
            begin
               // overrun ends the cycle at once
               st_d = ST_SLEEP;
               lp_d = (ctimer_q + 1'b1) < (cycle_len - 1'b1);
            end
         end
         ST_SLEEP:
         begin
            if (ctimer_q >= cycle_len - 1'b1)
            begin
               st_d = ST_IDLE;
               lp_d = 1'b0;
            end
         end
      endcase
      // Leaving standby aborts the cycle; touches keep their last state
      if (!STANDBY_I)
      begin
         st_d      = ST_IDLE;
         en_d      = 1'b0;
         lp_d      = 1'b0;
         trk_valid = '0;
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (SRST_I)
      begin
         st_q     <= ST_IDLE;
         ch_q     <= 2'h0;
         nsamp_q  <= 8'h00;
         stimer_q <= '0;
         ctimer_q <= '0;
         en_q     <= 1'b0;
         lp_q     <= 1'b0;
         touch_q  <= '0;
      end
      else
      begin
         st_q     <= st_d;
         ch_q     <= ch_d;
         nsamp_q  <= nsamp_d;
         stimer_q <= stimer_d;
         ctimer_q <= ctimer_d;
         en_q     <= en_d;
         lp_q     <= lp_d;
         touch_q  <= touch_d;
      end
   end

   // Sample summing for the channel in progress
   sample_accumulator u_acc (
      .clk_i   (CORE_CLK_I),
      .rst_i   (SRST_I),
      .clear_i (acc_clr),
      .add_i   (acc_add),
      .value_i (SAMPLE_COUNT_I),
      .sum_o   (acc_sum)
   );

   // One baseline tracker per channel, fed with the averaged reading
   for (genvar g = 0; g < NUM_CH; g++)
   begin : g_trk
      baseline_tracker u_trk (
         .clk_i     (CORE_CLK_I),
         .rst_i     (SRST_I),
         .valid_i   (trk_valid[g]),
         .touched_i (touch_now),
         .value_i   (avg_val[COUNT_W-1:0]),
         .scale_i   (BASELINE_SCALE_I),
         .base_o    (trk_base[g]),
         .view_o    (trk_view[g])
      );
   end

   // Outputs straight from flops
   assign REG_RDATA_O = rdata_q;
   assign SAMPLE_EN_O = en_q;
   assign SAMPLE_CH_O = ch_q;
   assign LOW_POWER_O = lp_q;
   assign TOUCH_O     = touch_q;

endmodule
`default_nettype wire

// File: testbench/front_end_model.sv
`timescale 1ns/10ps
`default_nettype none
module front_end_model
   import standby_touch_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               sample_en_i,
   input  wire logic [1:0]         sample_ch_i,
   input  wire logic [COUNT_W-1:0] ch1_count_i,
   input  wire logic [COUNT_W-1:0] ch2_count_i,
   input  wire logic [COUNT_W-1:0] ch3_count_i,
   output logic      [COUNT_W-1:0] count_o
);
   logic [COUNT_W-1:0] idle_q = 16'h0000;

   // Outside a burst the count toggles, so a stray capture shows up as a wrong touch
   always_comb
   begin
      count_o = idle_q;
      if (sample_en_i && sample_ch_i == 2'h0) count_o = ch1_count_i;
      if (sample_en_i && sample_ch_i == 2'h1) count_o = ch2_count_i;
      if (sample_en_i && sample_ch_i == 2'h2) count_o = ch3_count_i;
   end

   always_ff @(posedge clk_i)
   begin
      idle_q <= ~count_o;
   end
endmodule
`default_nettype wire

// File: testbench/standby_touch_properties.sv
`timescale 1ns/10ps
`default_nettype none
module standby_touch_checker
   import standby_touch_pkg::*;
#(
   parameter int SAMPLE_CYCLES = SAMPLE_BASE_CYCLES
)
(
   input  wire logic              CORE_CLK_I,
   input  wire logic              SRST_I,
   input  wire logic [ADDR_W-1:0] REG_ADDR_I,
   input  wire logic [DATA_W-1:0] REG_WDATA_I,
   input  wire logic              REG_WR_I,
   input  wire logic              REG_RD_I,
   input  wire logic [DATA_W-1:0] REG_RDATA_O,
   input  wire logic              STANDBY_I,
   input  wire logic              CHANNEL1_STANDBY_ENABLE_I,
   input  wire logic              CHANNEL2_STANDBY_ENABLE_I,
   input  wire logic              CHANNEL3_STANDBY_ENABLE_I,
   input  wire logic              SAMPLE_EN_O,
   input  wire logic [1:0]        SAMPLE_CH_O,
   input  wire logic              LOW_POWER_O,
   input  wire logic [NUM_CH-1:0] TOUCH_O
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (SRST_I);

   logic [7:0]  cfg_q, cfg_d, gain_q, gain_d;
   logic [31:0] run_q, run_d, want;
   logic [2:0]  en;

   // Shadow of host settings; run length counts cycles of one sampling burst
   always_comb
   begin
      cfg_d = cfg_q;
      gain_d = gain_q;
      if (REG_WR_I && REG_ADDR_I == OFS_SENSING_CONFIG) cfg_d = REG_WDATA_I;
      if (REG_WR_I && REG_ADDR_I == OFS_GAIN_SELECT) gain_d = REG_WDATA_I & GAIN_MASK;
      run_d = SAMPLE_EN_O ? run_q + 32'h1 : 32'h0;
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (SRST_I)
      begin
         cfg_q <= RST_SENSING_CONFIG;
         gain_q <= RST_GAIN_SELECT;
         run_q <= 32'h0;
      end
      else
      begin
         cfg_q <= cfg_d;
         gain_q <= gain_d;
         run_q <= run_d;
      end
   end

   // Burst length is samples times sample time; valid only while settings stay put
   assign want = (32'h1 << cfg_q[COUNT_MSB:COUNT_LSB]) *
                 (32'(SAMPLE_CYCLES) << cfg_q[SPER_MSB:SPER_LSB]);
   assign en = {CHANNEL3_STANDBY_ENABLE_I, CHANNEL2_STANDBY_ENABLE_I, CHANNEL1_STANDBY_ENABLE_I};

   a_sample_needs_standby: assert property (SAMPLE_EN_O |-> $past(STANDBY_I))
      else $error("sampling outside standby");
   a_channel_enabled: assert property (SAMPLE_EN_O |-> en[SAMPLE_CH_O])
      else $error("disabled channel sampled");
   a_channel_steady: assert property (SAMPLE_EN_O && $past(SAMPLE_EN_O) |-> $stable(SAMPLE_CH_O))
      else $error("channel changed inside a burst");
   a_channel_order: assert property ($rose(SAMPLE_EN_O) && $past(SAMPLE_EN_O, 2)
      |-> SAMPLE_CH_O > $past(SAMPLE_CH_O)) else $error("channels not ascending");
   a_burst_length: assert property ($fell(SAMPLE_EN_O) && STANDBY_I && $past(STANDBY_I)
      |-> run_q == want) else $error("burst length wrong");
   a_power_exclusive: assert property (LOW_POWER_O |-> !SAMPLE_EN_O && $past(STANDBY_I))
      else $error("low power while sampling");
   a_touch_at_reduce: assert property (TOUCH_O != $past(TOUCH_O)
      |-> $past(SAMPLE_EN_O, 2) && !$past(SAMPLE_EN_O)) else $error("touch moved off reduce");
   a_config_read: assert property (REG_RD_I && REG_ADDR_I == OFS_SENSING_CONFIG
      |=> REG_RDATA_O == $past(cfg_q)) else $error("config readback wrong");
   a_gain_read: assert property (REG_RD_I && REG_ADDR_I == OFS_GAIN_SELECT
      |=> REG_RDATA_O == $past(gain_q)) else $error("gain readback wrong");
   a_rdata_holds: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
      else $error("read data moved without read");

   c_touch: cover property ($rose(TOUCH_O[0]));
   c_low_power: cover property ($rose(LOW_POWER_O));
   c_sum_mode: cover property ($fell(SAMPLE_EN_O) && cfg_q[SUM_SEL_BIT]);
endmodule

bind standby_touch_sensing standby_touch_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_checker (
   .CORE_CLK_I(CORE_CLK_I), .SRST_I(SRST_I), .REG_ADDR_I(REG_ADDR_I),
   .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
   .REG_RDATA_O(REG_RDATA_O), .STANDBY_I(STANDBY_I),
   .CHANNEL1_STANDBY_ENABLE_I(CHANNEL1_STANDBY_ENABLE_I),
   .CHANNEL2_STANDBY_ENABLE_I(CHANNEL2_STANDBY_ENABLE_I),
   .CHANNEL3_STANDBY_ENABLE_I(CHANNEL3_STANDBY_ENABLE_I), .SAMPLE_EN_O(SAMPLE_EN_O),
   .SAMPLE_CH_O(SAMPLE_CH_O), .LOW_POWER_O(LOW_POWER_O), .TOUCH_O(TOUCH_O));
`default_nettype wire

// File: testbench/standby_touch_sensing_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module standby_touch_sensing_tb_top;
   import standby_touch_pkg::*;
   localparam int SCYC = 4;
   localparam int CCYC = 200;

   logic        clk, srst, wr, rd, stby, en1, en2, en3, sen, lp;
   logic [7:0]  addr, wdata, rdata;
   logic [3:0]  scale;
   logic [15:0] count, c1, c2, c3;
   logic [1:0]  sch;
   logic [2:0]  touch;
   int          err_count, check_count, cycles;
   logic [7:0]  ofs [7] = '{8'h41, 8'h42, 8'h43, 8'h50, 8'h51, 8'h52, 8'h44};
   logic [7:0]  rstv [7] = '{8'h39, 8'h02, 8'h40, 8'hC8, 8'hC8, 8'hC8, 8'h00};
   logic [7:0]  wofs [5] = '{8'h41, 8'h42, 8'h43, 8'h50, 8'h44};
   logic [7:0]  wexp [5] = '{8'hFF, 8'h07, 8'h7F, 8'hC8, 8'h00};
   logic [7:0]  tcfg [9] = '{8'h00, 8'h15, 8'h2A, 8'h3F, 8'h40, 8'h51, 8'h62, 8'h73, 8'h7C};

   standby_touch_sensing #(.SAMPLE_CYCLES(SCYC), .CYCLE_CYCLES(CCYC)) DUT (
      .CORE_CLK_I(clk), .SRST_I(srst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
      .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .STANDBY_I(stby),
      .CHANNEL1_STANDBY_ENABLE_I(en1), .CHANNEL2_STANDBY_ENABLE_I(en2),
      .CHANNEL3_STANDBY_ENABLE_I(en3), .BASELINE_SCALE_I(scale), .SAMPLE_COUNT_I(count),
      .SAMPLE_EN_O(sen), .SAMPLE_CH_O(sch), .LOW_POWER_O(lp), .TOUCH_O(touch));

   front_end_model u_front (.clk_i(clk), .sample_en_i(sen), .sample_ch_i(sch),
      .ch1_count_i(c1), .ch2_count_i(c2), .ch3_count_i(c3), .count_o(count));

   // Free-running clock and a cycle ceiling against hangs
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         err_count++;
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Strobes go up for exactly one rising edge; data is read once it has settled
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask

   task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      check({24'h0, rdata}, {24'h0, exp});
   endtask

   task automatic wait_lp();
      int n = 0;
      @(negedge clk);
      while (lp !== 1'b1 && n < 20000)
      begin
         @(negedge clk);
         n++;
      end
      check({31'h0, lp}, 32'h1);
   endtask

   task automatic touch_run(input logic [7:0] cfg, input logic [7:0] gain,
                            input logic [7:0] th, input logic [2:0] exp);
      wr_reg(OFS_SENSING_CONFIG, cfg);
      wr_reg(OFS_GAIN_SELECT, gain);
      wr_reg(OFS_TOUCH_THRESH, th);
      stby = 1'b1;
      wait_lp();
      check({29'h0, touch}, {29'h0, exp});
      stby = 1'b0;
      repeat (4) @(negedge clk);
   endtask

   // One channel: burst length, start latency, period and the low-power fill
   task automatic measure(input logic [7:0] cfg);
      int hi = 0;
      int per = 0;
      int low_pw = 0;
      int nl = (1 << cfg[6:4]) * (SCYC << cfg[3:2]);
      int pp = CCYC * (cfg[1:0] + 1);
      int lo = (nl + 1 < pp) ? pp : nl + 1;
      wr_reg(OFS_SENSING_CONFIG, cfg);
      stby = 1'b1;
      while (sen !== 1'b1 && per < 100)
      begin
         @(negedge clk);
         per++;
      end
      check(per, 1);
      while (sen === 1'b1 && hi < 10000)
      begin
         @(negedge clk);
         hi++;
      end
      per = hi;
      while (sen !== 1'b1 && per < 10000)
      begin
         @(negedge clk);
         per++;
         if (lp === 1'b1) low_pw++;
      end
      stby = 1'b0;
      check(hi, nl);
      check(per >= lo && per <= lo + 2, 1);
      check(low_pw != 0, nl + 1 < pp);
      repeat (4) @(negedge clk);
   endtask

   initial
   begin
      {srst, wr, rd, stby, en1, en2, en3} = 7'b1000000;
      addr = 8'h00;
      wdata = 8'h00;
      scale = 4'h0;
      {c1, c2, c3} = {16'h00C8, 16'h00C8, 16'h00C8};
      repeat (16) @(negedge clk);
      srst = 1'b0;
      // Reset values, masked fields, a read-only baseline and an unmapped place
      for (int i = 0; i < 7; i++) rd_check(ofs[i], rstv[i]);
      for (int i = 0; i < 5; i++)
      begin
         wr_reg(wofs[i], 8'hFF);
         rd_check(wofs[i], wexp[i]);
      end
      $display("register test done");
      // Baseline refresh after a full block of untouched readings
      {c1, c2} = {16'h00D0, 16'h00D0};
      {en1, en2} = 2'b11;
      wr_reg(OFS_SENSING_CONFIG, 8'h00);
      wr_reg(OFS_GAIN_SELECT, 8'h02);
      wr_reg(OFS_TOUCH_THRESH, 8'h40);
      stby = 1'b1;
      repeat (66)
      begin
         wait_lp();
         while (lp === 1'b1) @(negedge clk);
      end
      stby = 1'b0;
      rd_check(OFS_CH1_BASELINE, 8'hD0);
      rd_check(OFS_CH2_BASELINE, 8'hD0);
      rd_check(OFS_CH3_BASELINE, 8'hC8);
      scale = 4'h1;
      repeat (2) @(negedge clk);
      rd_check(OFS_CH1_BASELINE, 8'h68);
      scale = 4'h4;
      repeat (2) @(negedge clk);
      rd_check(OFS_CH2_BASELINE, 8'h0D);
      scale = 4'h0;
      $display("baseline test done");
      // Deltas 11h and 10h over the refreshed baseline; channel three stays off
      {c1, c2, c3} = {16'h00E1, 16'h00E0, 16'h01FF};
      touch_run(8'h00, 8'h00, 8'h10, 3'b001);
      for (int g = 0; g < 8; g++) touch_run(8'h00, g[7:0], 8'h00, (g < 5) ? 3'b011 : 3'b000);
      touch_run(8'h10, 8'h00, 8'h7F, 3'b000);
      touch_run(8'h90, 8'h00, 8'h7F, 3'b011);
      // Channel two skipped and keeps its last touch; channel three saturates in average mode
      {en2, en3} = 2'b01;
      touch_run(8'h00, 8'h00, 8'h10, 3'b111);
      $display("touch test done");
      en3 = 1'b0;
      for (int i = 0; i < 9; i++) measure(tcfg[i]);
      $display("timing test done");
      close_out();
   end
endmodule
`default_nettype wire
